/* File: sio_burst_port.sv */
// Operation
// [R1] gap code stretches frame to 1,2,4,8 words; code skips the gap on the external clock
// [R2] word count field selects 1..8 words
// [R3] 4-bit words use low nibble, zero upper
// [R4] words move from lowest buffer address upward
// [R5] word count kept after transfer ends
// [R6] software writes count only while stopped
// [R7] count register is write-only, whole byte
// [R8] status bit 7 shows transfer active
// [R9] status bit 6 shows shifting active
// [R10] run clear ends after word; abort immediate
// [R11] clock select: six internal, external on 111
// [R12] internal rates fc/2^13..fc/2^4, slow tap
// [R13] internal clock driven out, idles high
// [R14] internal clock waits for buffer access
// [R15] external clock pulses last four cycles
// [R16] transmit bit changes on clock falling edge
// [R17] receive bit sampled on clock rising edge
// [R18] 4 or 8 bit words, LSB first
// [R19] done pulse when count of words moved
// [R20] stop and abort before mode change
// [R21] shared address: write control, read status
//
// The strobed register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "sio_defs.svh"

module sio_burst_port
    import sio_pkg::*;
#(
    parameter int SLOW_HALF = `SIO_HALF_SLOW
) (
    // clock and reset
    input  wire logic                   sys_clk_i,
    input  wire logic                   rstn_i,
    // register port
    input  wire logic [`SIO_ADDR_W-1:0] addr_i,
    input  wire logic [7:0]             wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic      [7:0]             rdata_o,
    // serial pins
    input  wire logic                   sck_i,
    output logic                        sck_o,
    output logic                        sck_oe_n_o,
    input  wire logic                   si_i,
    output logic                        so_o,
    // event
    output logic                        transfer_done_irq_o
);

    // ****************************************
    // registers and state
    // ****************************************
    logic        run_r;
    xfer_mode_e  mode_r;
    clk_sel_t    sck_sel_r;
    logic [1:0]  gap_sel_r;
    logic [2:0]  count_r;
    logic        tap_r;
    logic        low_r;
    logic [7:0]  buf_r [8];
    sio_state_e  state_r;
    logic [2:0]  idx_r;
    logic [2:0]  bit_r;
    logic [7:0]  tx_sh_r;
    logic [7:0]  rx_sh_r;
    logic [6:0]  gap_r;
    logic        active_r;
    logic        shift_r;
    logic        touch_r;
    logic        sck_r;

    // ****************************************
    // decode
    // ****************************************
    function automatic logic is_buf(input logic [`SIO_ADDR_W-1:0] a);
        return (a >= `SIO_ADDR_BUF0) && (a <= `SIO_ADDR_BUF_LAST);
    endfunction

    logic wr_ca;
    logic abort_req;
    logic buf_wr;
    logic buf_rd;
    assign wr_ca     = wr_i && (addr_i == `SIO_ADDR_CTRL_A);
    assign abort_req = wr_ca && wdata_i[`SIO_CA_ABORT_BIT];
    assign buf_wr    = wr_i && is_buf(addr_i);
    assign buf_rd    = rd_i && is_buf(addr_i);

    // mode properties
    logic ext_clk;
    logic narrow;
    logic rx_on;
    logic tx_on;
    assign ext_clk = (sck_sel_r == 3'b111);                 // see [R11]
    assign narrow  = (mode_r == MODE_TX4) || (mode_r == MODE_RX4);
    assign rx_on   = (mode_r == MODE_TRX8) || (mode_r == MODE_RX8)
                  || (mode_r == MODE_RX4);
    assign tx_on   = (mode_r == MODE_TX8) || (mode_r == MODE_TX4)
                  || (mode_r == MODE_TRX8);

    // ****************************************
    // clock sources
    // ****************************************
    logic       tick;
    logic       start;
    logic [1:0] pin_lvl;
    logic [1:0] pin_rise;
    logic [1:0] pin_fall;

    sio_rate_div #(
        .SLOW_HALF (SLOW_HALF)
    ) u_div (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .restart_i (start),
        .sel_i     (sck_sel_r),
        .slow_i    (tap_r | low_r),                          // see [R12]
        .tick_o    (tick)
    );

    sio_pin_sync #(
        .W (2)
    ) u_sync (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .pin_i     ({si_i, sck_i}),
        .lvl_o     (pin_lvl),
        .rise_o    (pin_rise),
        .fall_o    (pin_fall)
    );

    // edges of the serial clock, internal or from the pin
    logic ev_fall;
    logic ev_rise;
    logic shifting;
    assign shifting = (state_r == ST_SHIFT);
    assign ev_fall  = shifting && (ext_clk ? pin_fall[0] : tick && sck_r);
    assign ev_rise  = shifting && (ext_clk ? pin_rise[0] : tick && !sck_r);

    // word and burst boundaries
    logic       last_bit;
    logic       word_end;
    logic       burst_end;
    logic [7:0] rx_next;
    logic [7:0] rx_word;
    assign last_bit  = (bit_r == (narrow ? 3'd3 : 3'd7));    // see [R18]
    assign word_end  = ev_rise && last_bit;
    assign burst_end = (idx_r == count_r);                   // see [R2]
    assign rx_next   = {pin_lvl[1], rx_sh_r[7:1]};           // see [R18]
    assign rx_word   = narrow ? {4'h0, rx_next[7:4]} : rx_next; // see [R3]
    assign start     = (state_r == ST_IDLE) && run_r && !abort_req;

    // extra half ticks of frame gap, internal clock only
    logic [6:0] gap_len;
    always_comb begin
        case (gap_sel_r)                                     // see [R1]
            2'b01:   gap_len = narrow ? 7'd8  : 7'd16;
            2'b10:   gap_len = narrow ? 7'd24 : 7'd48;
            2'b11:   gap_len = narrow ? 7'd56 : 7'd112;
            default: gap_len = 7'd0;
        endcase
    end

    // ****************************************
    // software registers
    // ****************************************
    // control a: run, mode, clock; abort is never stored
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            run_r     <= 1'(`SIO_CTRL_A_RST >> `SIO_CA_RUN_BIT);
            mode_r    <= MODE_TX8;
            sck_sel_r <= 3'b000;
        end else if (wr_ca) begin
            run_r     <= wdata_i[`SIO_CA_RUN_BIT];
            mode_r    <= xfer_mode_e'(wdata_i[`SIO_CA_MODE_HI:`SIO_CA_MODE_LO]);
            sck_sel_r <= wdata_i[`SIO_CA_SCK_HI:`SIO_CA_SCK_LO];
        end
    end

    // control b: write only, held after the burst ends
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            {gap_sel_r, count_r} <= `SIO_CTRL_B_RST;
        end else if (wr_i && addr_i == `SIO_ADDR_CTRL_B) begin  // see [R21]
            gap_sel_r <= wdata_i[`SIO_CB_GAP_HI:`SIO_CB_GAP_LO];
            count_r   <= wdata_i[`SIO_CB_CNT_HI:`SIO_CB_CNT_LO]; // see [R5]
        end
    end

    // speed tap and low-speed mode
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            {low_r, tap_r} <= `SIO_SPEED_RST;
        end else if (wr_i && addr_i == `SIO_ADDR_SPEED) begin
            tap_r <= wdata_i[`SIO_SP_TAP_BIT];
            low_r <= wdata_i[`SIO_SP_LOW_BIT];
        end
    end

    // data buffer; a received word is stored last so it wins
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < 8; i++)
                buf_r[i] <= 8'h00;
        end else begin
            if (buf_wr)
                buf_r[addr_i[2:0]] <= wdata_i;
            if (word_end && rx_on)
                buf_r[idx_r] <= rx_word;                     // see [R4]
        end
    end

    // a buffer write (transmit modes) or buffer read (receive-only modes) releases the automatic wait; set wins
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i)
            touch_r <= 1'b0;
        else if ((tx_on && buf_wr) || (!tx_on && buf_rd))
            touch_r <= 1'b1;                                 // see [R14]
        else if (start || (state_r == ST_WAIT && touch_r))
            touch_r <= 1'b0;
    end

    // read data: only in the cycle after the strobe
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i && is_buf(addr_i)) begin
            rdata_o <= buf_r[addr_i[2:0]];
        end else if (rd_i && addr_i == `SIO_ADDR_STATUS) begin // see [R21]
            rdata_o <= 8'h00;
            rdata_o[`SIO_ST_ACTIVE_BIT] <= active_r;          // see [R8]
            rdata_o[`SIO_ST_SHIFT_BIT]  <= shift_r;           // see [R9]
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            state_r  <= ST_IDLE;
            idx_r    <= 3'd0;
            bit_r    <= 3'd0;
            gap_r    <= 7'd0;
            active_r <= 1'b0;
            tx_sh_r  <= 8'h00;
            rx_sh_r  <= 8'h00;
            transfer_done_irq_o <= 1'b0;
        end else begin
            transfer_done_irq_o <= 1'b0;
            if (abort_req) begin
                state_r  <= ST_IDLE;                         // see [R10]
                active_r <= 1'b0;
            end else begin
                case (state_r)
                    ST_IDLE: begin
                        if (run_r) begin
                            state_r  <= ST_SHIFT;
                            active_r <= 1'b1;
                            idx_r    <= 3'd0;                // see [R4]
                            bit_r    <= 3'd0;
                            tx_sh_r  <= buf_r[0];
                        end
                    end
                    ST_SHIFT: begin
                        if (ev_fall)
                            tx_sh_r <= tx_sh_r >> 1;         // see [R18]
                        if (ev_rise) begin
                            rx_sh_r <= rx_next;              // see [R17]
                            bit_r   <= bit_r + 3'd1;
                        end
                        if (word_end) begin
                            bit_r <= 3'd0;
                            if (!run_r) begin
                                state_r  <= ST_IDLE;         // see [R10]
                                active_r <= 1'b0;
                            end else if (burst_end) begin
                                transfer_done_irq_o <= 1'b1; // see [R19]
                                state_r <= ST_WAIT;          // see [R14]
                            end else begin
                                idx_r   <= idx_r + 3'd1;     // see [R4]
                                tx_sh_r <= buf_r[idx_r + 3'd1];
                                gap_r   <= gap_len;
                                if (!ext_clk && gap_len != 7'd0)
                                    state_r <= ST_GAP;       // see [R1]
                            end
                        end
                    end
                    ST_GAP: begin
                        if (!run_r) begin
                            state_r  <= ST_IDLE;
                            active_r <= 1'b0;
                        end else if (tick) begin
                            gap_r <= gap_r - 7'd1;
                            if (gap_r == 7'd1)
                                state_r <= ST_SHIFT;
                        end
                    end
                    ST_WAIT: begin
                        if (!run_r) begin
                            state_r  <= ST_IDLE;
                            active_r <= 1'b0;
                        end else if (touch_r) begin
                            state_r <= ST_SHIFT;             // see [R14]
                            idx_r   <= 3'd0;
                            tx_sh_r <= buf_r[0];
                        end
                    end
                    default: begin
                        state_r  <= ST_IDLE;
                        active_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    // shift status follows the shifting state
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i)
            shift_r <= 1'b0;
        else
            shift_r <= shifting && !abort_req && !word_end;  // see [R9]
    end

    // ****************************************
    // pins
    // ****************************************
    // internal clock idles high and toggles on each tick
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            sck_r      <= 1'b1;
            sck_o      <= 1'b1;
            sck_oe_n_o <= 1'b1;
        end else begin
            if (!shifting || ext_clk)
                sck_r <= 1'b1;                               // see [R13]
            else if (tick)
                sck_r <= !sck_r;
            sck_o      <= (!shifting || ext_clk) | (sck_r ^ tick); // no lag
            sck_oe_n_o <= ext_clk;                           // see [R13]
        end
    end

    // transmit bit changes on the falling edge
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i)
            so_o <= 1'b1;
        else if (ev_fall && tx_on)
            so_o <= tx_sh_r[0];                              // see [R16]
    end

endmodule : sio_burst_port
`default_nettype wire

/* File: sio_burst_port_props.sv */
`timescale 1ns/10ps
`default_nettype none
`include "sio_defs.svh"

module sio_burst_port_props #(
    parameter int SLOW_HALF = 20
) (
    // clock and reset
    input wire logic                   sys_clk_i,
    input wire logic                   rstn_i,
    // register port
    input wire logic [`SIO_ADDR_W-1:0] addr_i,
    input wire logic [7:0]             wdata_i,
    input wire logic                   wr_i,
    input wire logic                   rd_i,
    input wire logic [7:0]             rdata_o,
    // serial pins
    input wire logic                   sck_i,
    input wire logic                   sck_o,
    input wire logic                   sck_oe_n_o,
    input wire logic                   si_i,
    input wire logic                   so_o,
    // event
    input wire logic                   transfer_done_irq_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);

    // ****************************************
    // register port
    // ****************************************
    property p_rdata_idle;
        !$past(rd_i) |-> rdata_o == 8'h00;
    endproperty
    a_rdata_idle:
        assert property (p_rdata_idle) else $error("read data off slot");
    property p_status_pad;
        rd_i && addr_i == 12'hf99 |=> rdata_o[5:0] == 6'h00;
    endproperty
    a_status_pad:
        assert property (p_status_pad) else $error("status pad bits set");
    property p_unmapped;
        rd_i && addr_i > 12'hf9a |=> rdata_o == 8'h00;
    endproperty
    a_unmapped:
        assert property (p_unmapped) else $error("unmapped read not 0");
    // shifting can only be seen inside an active transfer
    property p_shift_active;
        rd_i && addr_i == 12'hf99 |=> !(rdata_o[6] && !rdata_o[7]);
    endproperty
    a_shift_active:
        assert property (p_shift_active) else $error("shift w/o active");

    // ****************************************
    // serial side
    // ****************************************
    property p_done_pulse;
        transfer_done_irq_o |=> !transfer_done_irq_o;
    endproperty
    a_done_pulse:
        assert property (p_done_pulse) else $error("done not a pulse");
    property p_done_sck_high;
        transfer_done_irq_o && !sck_oe_n_o |-> sck_o;
    endproperty
    a_done_sck_high:
        assert property (p_done_sck_high) else $error("done with sck low");
    // register writes may restart the line, so they are excluded
    property p_so_hold;
        !sck_oe_n_o && sck_o && $past(sck_o) && !$past(wr_i)
            && !$past(wr_i, 2) |-> $stable(so_o);
    endproperty
    a_so_hold:
        assert property (p_so_hold) else $error("so moved off fall");
    // fastest internal rate still keeps each low phase 8 cycles
    property p_sck_low_min;
        $fell(sck_o) && !sck_oe_n_o |=> !sck_o [*7];
    endproperty
    a_sck_low_min:
        assert property (p_sck_low_min) else $error("sck low too short");
endmodule : sio_burst_port_props

bind sio_burst_port sio_burst_port_props #(.SLOW_HALF(SLOW_HALF)) u_props (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .sck_i(sck_i), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n_o), .si_i(si_i),
    .so_o(so_o), .transfer_done_irq_o(transfer_done_irq_o)
);
`default_nettype wire

/* File: sio_burst_port_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "sio_defs.svh"

module sio_burst_port_tb;
    logic                   sys_clk_i = 1'b0;
    logic                   rstn_i    = 1'b0;
    logic [`SIO_ADDR_W-1:0] addr_i    = '0;
    logic [7:0]             wdata_i   = 8'h00;
    logic                   wr_i      = 1'b0;
    logic                   rd_i      = 1'b0;
    logic [7:0]             rdata_o;
    logic                   sck_i;
    logic                   sck_o;
    logic                   sck_oe_n_o;
    logic                   si_i;
    logic                   so_o;
    logic                   transfer_done_irq_o;
    logic [15:0]            cap;
    int                     err_total  = 0;
    int                     n_compared = 0;

    // short slow-rate half period; no test selects the slow tap, so it does not shorten the run
    sio_burst_port #(.SLOW_HALF(20)) u_sio_burst_port (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .sck_i(sck_i), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n_o),
        .si_i(si_i), .so_o(so_o), .transfer_done_irq_o(transfer_done_irq_o)
    );
    sio_link_peer u_sio_link_peer (
        .sck_o(sck_o), .sck_oe_n_o(sck_oe_n_o), .so_o(so_o),
        .sck_i(sck_i), .si_i(si_i), .cap_o(cap)
    );

    // 10 MHz system clock
    initial begin
        forever #50 sys_clk_i = ~sys_clk_i;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge sys_clk_i);
        wr_i    <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge sys_clk_i);
        rd_i   <= 1'b0;
        @(negedge sys_clk_i);
        d = rdata_o;
    endtask : rd

    task automatic wait_done(input int lim);
        int k;
        k = 0;
        while (transfer_done_irq_o !== 1'b1 && k < lim) begin
            @(negedge sys_clk_i);
            k++;
        end
        chk(16'(k < lim), 16'h0001, "done pulse");
    endtask : wait_done

    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        logic [7:0] d;
        // the pin enable only leaves its reset level one edge after release
        @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        chk(16'(sck_o), 16'h0001, "sck idle");
        chk(16'(so_o), 16'h0001, "so idle");
        chk(16'(sck_oe_n_o), 16'h0000, "sck driven");
        rd(12'hf99, d);
        chk(16'(d), 16'h0000, "status idle");
        rd(12'hfa0, d);
        chk(16'(d), 16'h0000, "unmapped");
        $display("test reset done");
    endtask : t_reset

    // two 8-bit words at fc/2^4; count written only when asked
    task automatic t_tx(input logic set_cnt);
        logic [7:0] d;
        if (set_cnt) begin
            wr(12'hf99, 8'h01);
        end
        wr(12'hf90, 8'hb1);
        wr(12'hf91, 8'h4e);
        wr(12'hf98, 8'h85);
        rd(12'hf99, d);
        chk(16'(d[7]), 16'h0001, "active");
        wait_done(600);
        chk(cap, 16'h4eb1, "tx stream");
        wr(12'hf98, 8'h45);
        rd(12'hf99, d);
        chk(16'(d), 16'h0000, "abort");
        $display("test tx burst done");
    endtask : t_tx

    // one 4-bit word in on the external clock
    task automatic t_rx();
        logic [7:0] d;
        wr(12'hf98, 8'h77);
        wr(12'hf99, 8'h00);
        u_sio_link_peer.load(8'hd3);
        wr(12'hf98, 8'hb7);
        rd(12'hf99, d);
        chk(16'(d[7]), 16'h0001, "rx active");
        chk(16'(sck_oe_n_o), 16'h0001, "sck released");
        fork
            u_sio_link_peer.pulses(4);
            wait_done(200);
        join
        rd(12'hf90, d);
        chk(16'(d), 16'h0003, "rx nibble");
        wr(12'hf98, 8'h77);
        rd(12'hf99, d);
        chk(16'(d), 16'h0000, "rx abort");
        $display("test rx nibble done");
    endtask : t_rx

    // main sequence
    initial begin
        repeat (8) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        t_reset();
        t_tx(1'b1);
        t_tx(1'b0);
        t_rx();
        conclude();
    end

    // watchdog, far beyond the several hundred cycles the tests need
    initial begin
        #1000000;
        err_total++;
        $display("CHECK FAILED at %0t: timeout", $time);
        conclude();
    end
endmodule : sio_burst_port_tb
`default_nettype wire

/* File: sio_defs.svh */
`ifndef SIO_DEFS_SVH
`define SIO_DEFS_SVH

// ****************************************
// register map
// ****************************************
`define SIO_ADDR_W          12
`define SIO_ADDR_BUF0       12'hf90
`define SIO_ADDR_BUF_LAST   12'hf97
`define SIO_ADDR_CTRL_A     12'hf98
`define SIO_ADDR_CTRL_B     12'hf99
`define SIO_ADDR_STATUS     12'hf99
`define SIO_ADDR_SPEED      12'hf9a

// ****************************************
// field positions
// ****************************************
`define SIO_CA_RUN_BIT      7
`define SIO_CA_ABORT_BIT    6
`define SIO_CA_MODE_HI      5
`define SIO_CA_MODE_LO      3
`define SIO_CA_SCK_HI       2
`define SIO_CA_SCK_LO       0
`define SIO_CB_GAP_HI       4
`define SIO_CB_GAP_LO       3
`define SIO_CB_CNT_HI       2
`define SIO_CB_CNT_LO       0
`define SIO_ST_ACTIVE_BIT   7
`define SIO_ST_SHIFT_BIT    6
`define SIO_SP_TAP_BIT      0
`define SIO_SP_LOW_BIT      1

// ****************************************
// reset values
// ****************************************
`define SIO_CTRL_A_RST      8'h00
`define SIO_CTRL_B_RST      5'h00
`define SIO_SPEED_RST       2'h0

// ****************************************
// timing: half periods in system clocks
// ****************************************
`define SIO_HALF_FC13       14'h1000
`define SIO_HALF_FC8        14'h0080
`define SIO_HALF_FC7        14'h0040
`define SIO_HALF_FC6        14'h0020
`define SIO_HALF_FC5        14'h0010
`define SIO_HALF_FC4        14'h0008
`define SIO_HALF_SLOW       14'h1e84

`endif

/* File: sio_link_peer.sv */
`timescale 1ns/10ps
`default_nettype none

module sio_link_peer (
    // device pins
    input  wire logic   sck_o,
    input  wire logic   sck_oe_n_o,
    input  wire logic   so_o,
    output logic        sck_i,
    output logic        si_i,
    // captured transmit stream
    output logic [15:0] cap_o
);
    logic       ext_clk_r = 1'b1;
    logic [7:0] pat_r     = 8'h00;
    logic [2:0] idx_r     = 3'h7;

    // pin level: pull-up keeps the line high while nobody drives it
    assign sck_i = sck_oe_n_o ? ext_clk_r : sck_o;
    assign si_i  = pat_r[idx_r];
    initial cap_o = 16'h0000;

    // take device data on the rising pin edge, first bit ends up lowest
    always @(posedge sck_i) begin
        cap_o <= {so_o, cap_o[15:1]};
    end

    // next receive bit goes out on the falling edge, lsb first
    always @(negedge sck_i) begin
        if (sck_oe_n_o) begin
            idx_r <= idx_r + 3'h1;
        end
    end

    task automatic load(input logic [7:0] pat);
        pat_r = pat;
        idx_r = 3'h7;
    endtask : load

    // each level stands 400 ns, four system cycles; offset breaks phase
    task automatic pulses(input int n);
        #37;
        repeat (n) begin
            #400 ext_clk_r = 1'b0;
            #400 ext_clk_r = 1'b1;
        end
    endtask : pulses
endmodule : sio_link_peer
`default_nettype wire

/* File: sio_pin_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module sio_pin_sync #(
    parameter int W = 2
) (
    // clock and reset
    input  wire logic         sys_clk_i,
    input  wire logic         rstn_i,
    // pins
    input  wire logic [W-1:0] pin_i,
    // synchronised levels and edges
    output logic      [W-1:0] lvl_o,
    output logic      [W-1:0] rise_o,
    output logic      [W-1:0] fall_o
);

    initial begin
        if (W < 1)
            $error("W must be positive");
    end

    logic [W-1:0] meta_r;
    logic [W-1:0] prev_r;

    // two sync stages plus an edge stage; the first stage feeds no logic
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            meta_r <= {W{1'b1}};
            lvl_o  <= {W{1'b1}};
            prev_r <= {W{1'b1}};
        end else begin
            meta_r <= pin_i;
            lvl_o  <= meta_r;
            prev_r <= lvl_o;
        end
    end

    // edge pulses from the settled stages
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_edge
            assign rise_o[g] = lvl_o[g] & ~prev_r[g];
            assign fall_o[g] = ~lvl_o[g] & prev_r[g];
        end
    endgenerate

endmodule : sio_pin_sync
`default_nettype wire

/* File: sio_pkg.sv */
package sio_pkg;

    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_GAP   = 2'b10,
        ST_WAIT  = 2'b11
    } sio_state_e;

    // transfer modes
    typedef enum logic [2:0] {
        MODE_TX8   = 3'b000,
        MODE_TX4   = 3'b010,
        MODE_TRX8  = 3'b100,
        MODE_RX8   = 3'b101,
        MODE_RX4   = 3'b110
    } xfer_mode_e;

    typedef logic [2:0] clk_sel_t;

endpackage : sio_pkg

/* File: sio_rate_div.sv */
`timescale 1ns/10ps
`default_nettype none
`include "sio_defs.svh"

module sio_rate_div
    import sio_pkg::*;
#(
    parameter int SLOW_HALF = `SIO_HALF_SLOW
) (
    // clock and reset
    input  wire logic     sys_clk_i,
    input  wire logic     rstn_i,
    // control
    input  wire logic     restart_i,
    input  wire clk_sel_t sel_i,
    input  wire logic     slow_i,
    // half-period strobe
    output logic          tick_o
);

    initial begin
        if (SLOW_HALF < 1 || SLOW_HALF > 16383)
            $error("SLOW_HALF out of range");
    end

    logic [13:0] cnt_r;
    logic [13:0] half;

    // select half period; fc/2^13 gives way to the slow tap
    always_comb begin
        case (sel_i)
            3'b000:  half = slow_i ? SLOW_HALF[13:0] : `SIO_HALF_FC13;
            3'b001:  half = `SIO_HALF_FC8;
            3'b010:  half = `SIO_HALF_FC7;
            3'b011:  half = `SIO_HALF_FC6;
            3'b100:  half = `SIO_HALF_FC5;
            3'b101:  half = `SIO_HALF_FC4;
            default: half = `SIO_HALF_FC4;
        endcase
    end

    // free counter, realigned when a transfer starts from idle, not when a burst resumes from the wait
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i || restart_i) begin
            cnt_r  <= 14'h0000;
            tick_o <= 1'b0;
        end else if (cnt_r >= half - 14'h0001) begin
            cnt_r  <= 14'h0000;
            tick_o <= 1'b1;
        end else begin
            cnt_r  <= cnt_r + 14'h0001;
            tick_o <= 1'b0;
        end
    end

endmodule : sio_rate_div
`default_nettype wire
